// File: hw/scspi_map.svh
// Constants for the sensor configuration SPI slave
`ifndef SCSPI_MAP_SVH
`define SCSPI_MAP_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define SCSPI_ADDR_BITS 9
`define SCSPI_DATA_BITS 16
`define SCSPI_CNT_BITS 5
`define SCSPI_ADDR_LAST 5'h08
`define SCSPI_DATA_LAST 5'h0F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCSPI_CNT_RESET 5'h00
`define SCSPI_MEM_RESET 16'h0000

`endif

// File: hw/scspi_pkg.sv
// Types shared by the sensor configuration SPI slave
package scspi_pkg;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCSPI_IDLE,
    SCSPI_ADDR,
    SCSPI_TYPE,
    SCSPI_WRITE,
    SCSPI_READ,
    SCSPI_DONE
  } scspi_state_t;

  // ----------------------------------------------------------------
  // Register write towards the sensor core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] data;
  } scspi_wr_t;

endpackage : scspi_pkg

// File: hw/scspi_cfg_mem.sv
// Configuration register storage with registered read data
`timescale 1ns/100ps

module scspi_cfg_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input wire logic ref_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_reg[rd_addr_i];
  end

endmodule : scspi_cfg_mem

// File: hw/scspi_slave.sv
// Four-wire SPI slave giving a host access to configuration registers
`timescale 1ns/100ps
`include "scspi_map.svh"

// How it works
// - Each access carries a 9-bit address and one 16-bit data word.
// - After select falls, 9 address bits arrive MSB first and are captured.
// - Mosi is sampled at sck rising edges; host changes it on falling edges.
// - The tenth bit selects the access: high is write, low is read.
// - On write, 16 data bits MSB first are loaded into the addressed register.
// - On read, addressed register contents go out on miso MSB first.
// - Miso is released (output enable low) whenever no read data is driven.
// - Sck domain is asynchronous to the system clock and is synchronised.
module scspi_slave #(
  parameter int AW = `SCSPI_ADDR_BITS,
  parameter int DW = `SCSPI_DATA_BITS
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_sck_i,
  input wire logic spi_ss_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output scspi_pkg::scspi_wr_t cfg_wr_o,
  output logic cfg_wr_valid_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // All three pins go through the same depth so mosi stays aligned
  // with the detected sck edge.
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic sck_dly_reg;

  always_ff @(posedge ref_clk_i)
  begin
    meta_reg <= {spi_sck_i, spi_ss_n_i, spi_mosi_i};
    sync_reg <= meta_reg;
    sck_dly_reg <= sync_reg[2];
  end

  wire sck_s = sync_reg[2];
  wire ss_n_s = sync_reg[1];
  wire mosi_s = sync_reg[0];
  wire sck_rise = sck_s & ~sck_dly_reg;
  wire selected = ~ss_n_s;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  scspi_pkg::scspi_state_t state_reg;
  scspi_pkg::scspi_state_t state_next;
  logic [`SCSPI_CNT_BITS-1:0] cnt_reg;
  logic [`SCSPI_CNT_BITS-1:0] cnt_next;
  logic [DW-1:0] in_sh_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] addr_next;
  logic [DW-1:0] out_sh_reg;
  logic [DW-1:0] out_sh_next;
  logic oe_reg;
  logic oe_next;
  logic wr_pulse_reg;
  logic wr_pulse_next;
  scspi_pkg::scspi_wr_t wr_reg;
  logic [DW-1:0] mem_rd_data;

  wire [DW-1:0] in_sh_shift = {in_sh_reg[DW-2:0], mosi_s};
  wire [`SCSPI_CNT_BITS-1:0] cnt_inc = cnt_reg + `SCSPI_CNT_BITS'(1);
  wire addr_last = (cnt_reg == `SCSPI_ADDR_LAST);
  wire data_last = (cnt_reg == `SCSPI_DATA_LAST);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    out_sh_next = out_sh_reg;
    oe_next = oe_reg;
    wr_pulse_next = 1'b0;
    if (!selected)
    begin
      // Abort anything in flight; nothing is written
      state_next = scspi_pkg::SCSPI_IDLE;
      cnt_next = `SCSPI_CNT_RESET;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        scspi_pkg::SCSPI_IDLE:
        begin
          state_next = scspi_pkg::SCSPI_ADDR;
          cnt_next = `SCSPI_CNT_RESET;
        end
        scspi_pkg::SCSPI_ADDR:
        begin
          if (sck_rise)
          begin
            cnt_next = cnt_inc;
            if (addr_last)
            begin
              addr_next = in_sh_shift[AW-1:0];
              state_next = scspi_pkg::SCSPI_TYPE;
            end
          end
        end
        scspi_pkg::SCSPI_TYPE:
        begin
          if (sck_rise)
          begin
            cnt_next = `SCSPI_CNT_RESET;
            if (mosi_s)
            begin
              state_next = scspi_pkg::SCSPI_WRITE;
            end
            else
            begin
              state_next = scspi_pkg::SCSPI_READ;
              out_sh_next = mem_rd_data;
              oe_next = 1'b1;
            end
          end
        end
        scspi_pkg::SCSPI_WRITE:
        begin
          if (sck_rise)
          begin
            cnt_next = cnt_inc;
            if (data_last)
            begin
              wr_pulse_next = 1'b1;
              state_next = scspi_pkg::SCSPI_DONE;
            end
          end
        end
        scspi_pkg::SCSPI_READ:
        begin
          if (sck_rise)
          begin
            out_sh_next = {out_sh_reg[DW-2:0], 1'b0};
            cnt_next = cnt_inc;
            if (cnt_inc == `SCSPI_DATA_LAST)
            begin
              // Last bit held until select rises
              state_next = scspi_pkg::SCSPI_DONE;
            end
          end
        end
        scspi_pkg::SCSPI_DONE:
        begin
          state_next = scspi_pkg::SCSPI_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= scspi_pkg::SCSPI_IDLE;
      cnt_reg <= `SCSPI_CNT_RESET;
      oe_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      wr_pulse_reg <= wr_pulse_next;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      in_sh_reg <= `SCSPI_MEM_RESET;
      addr_reg <= '0;
      out_sh_reg <= `SCSPI_MEM_RESET;
      wr_reg <= '0;
    end
    else
    begin
      if (sck_rise && selected)
      begin
        in_sh_reg <= in_sh_shift;
      end
      addr_reg <= addr_next;
      out_sh_reg <= out_sh_next;
      if (wr_pulse_next)
      begin
        wr_reg <= '{addr: addr_reg, data: in_sh_shift};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  scspi_cfg_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(wr_pulse_reg),
    .wr_addr_i(wr_reg.addr),
    .wr_data_i(wr_reg.data),
    .rd_addr_i(addr_reg),
    .rd_data_o(mem_rd_data)
  );

  assign spi_miso_o = out_sh_reg[DW-1];
  assign spi_miso_oe_o = oe_reg;
  assign cfg_wr_o = wr_reg;
  assign cfg_wr_valid_o = wr_pulse_reg;
  assign busy_o = (state_reg != scspi_pkg::SCSPI_IDLE);

endmodule : scspi_slave

// File: testbench/scspi_slave_sva.sv
// Port checks for the configuration SPI slave
`timescale 1ns/100ps
module scspi_slave_chk (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic spi_sck_i,
  input wire logic spi_ss_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire scspi_pkg::scspi_wr_t cfg_wr_o,
  input wire logic cfg_wr_valid_o,
  input wire logic busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_wr_pulse: assert property (cfg_wr_valid_o |=> !cfg_wr_valid_o)
    else $error("write strobe too long");
  chk_wr_hold: assert property (!cfg_wr_valid_o |-> $stable(cfg_wr_o))
    else $error("write word moved");
  chk_wr_in_frame: assert property (cfg_wr_valid_o |-> busy_o)
    else $error("write outside frame");
  chk_oe_idle: assert property (spi_ss_n_i [*8] |-> !spi_miso_oe_o)
    else $error("miso driven while idle");
  chk_idle_quiet: assert property (spi_ss_n_i [*8] |-> !busy_o)
    else $error("busy while deselected");
  chk_oe_no_wr: assert property (spi_miso_oe_o |-> !cfg_wr_valid_o)
    else $error("write during read");
  chk_oe_start: assert property ($rose(spi_miso_oe_o) |->
    spi_sck_i && busy_o && !spi_ss_n_i)
    else $error("miso enabled off a rise");
  chk_miso_settle: assert property (spi_sck_i [*8] |->
    $stable(spi_miso_o))
    else $error("miso moved late");
endmodule : scspi_slave_chk

bind scspi_slave scspi_slave_chk chk_u (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .spi_sck_i(spi_sck_i),
  .spi_ss_n_i(spi_ss_n_i),
  .spi_miso_o(spi_miso_o),
  .spi_miso_oe_o(spi_miso_oe_o),
  .cfg_wr_o(cfg_wr_o),
  .cfg_wr_valid_o(cfg_wr_valid_o),
  .busy_o(busy_o)
);

// File: testbench/scspi_host_model.sv
// Behavioural SPI host framing configuration accesses
`timescale 1ns/100ps
module scspi_host_model (
  input wire logic ref_clk_i,
  input wire logic spi_miso_i,
  input wire logic spi_miso_oe_i,
  output logic spi_sck_o,
  output logic spi_ss_n_o,
  output logic spi_mosi_o
);
  // Released miso reads inverted so a late enable shows up
  wire logic miso_w = spi_miso_oe_i ? spi_miso_i : ~spi_miso_i;
  initial
  begin
    spi_sck_o = 1'b0;
    spi_ss_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // 80 ns half period
  task automatic half();
    repeat (10) @(posedge ref_clk_i);
  endtask : half
  task automatic frame(input logic [8:0] a, input logic w,
    input logic [15:0] d, input int nbits, output logic [15:0] q);
    logic [25:0] sh;
    sh = {a, w, d};
    q = 16'h0000;
    spi_ss_n_o <= 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      spi_mosi_o <= sh[25 - i];
      half();
      spi_sck_o <= 1'b1;
      half();
      spi_sck_o <= 1'b0;
      if (i >= 9 && i < 25) q = {q[14:0], miso_w};
    end
    half();
    half();
    spi_ss_n_o <= 1'b1;
    repeat (4) half();
  endtask : frame
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      half();
      spi_sck_o <= 1'b1;
      half();
      spi_sck_o <= 1'b0;
    end
  endtask : idle_clocks
endmodule : scspi_host_model

// File: testbench/tb.sv
// Self-checking bench for the configuration SPI slave
`timescale 1ns/100ps
module tb;
  logic ref_clk_i;
  logic sys_rst_i;
  logic sck, ss_n, mosi, miso, miso_oe, valid, busy;
  scspi_pkg::scspi_wr_t cfg_wr, last_wr;
  int failures = 0;
  int compares = 0;
  int n_wr = 0;
  logic [15:0] rd;
  scspi_slave uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .spi_sck_i(sck), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .cfg_wr_o(cfg_wr),
    .cfg_wr_valid_o(valid), .busy_o(busy));
  scspi_host_model host (.ref_clk_i(ref_clk_i), .spi_miso_i(miso),
    .spi_miso_oe_i(miso_oe), .spi_sck_o(sck), .spi_ss_n_o(ss_n),
    .spi_mosi_o(mosi));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i)
  begin
    if (valid === 1'b1)
    begin
      n_wr <= n_wr + 1;
      last_wr <= cfg_wr;
    end
  end
  task automatic check(input string what, input logic [24:0] seen,
    input logic [24:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic t_write_read(input logic [8:0] a, input logic [15:0] d);
    int n0;
    n0 = n_wr;
    host.frame(a, 1'b1, d, 26, rd);
    check("writes", 25'(n_wr - n0), 25'h0000001);
    check("write word", last_wr, {a, d});
    host.frame(a, 1'b0, 16'h0000, 26, rd);
    check("read data", 25'(rd), 25'(d));
    check("miso enable", 25'(miso_oe), 25'h0000000);
  endtask : t_write_read
  task automatic t_abort(input logic [8:0] a, input logic [15:0] d_old);
    int n0;
    n0 = n_wr;
    host.frame(a, 1'b1, ~d_old, 20, rd);
    check("aborted writes", 25'(n_wr - n0), 25'h0000000);
    host.frame(a, 1'b0, 16'h0000, 26, rd);
    check("kept data", 25'(rd), 25'(d_old));
  endtask : t_abort
  task automatic t_ignore();
    int n0;
    n0 = n_wr;
    host.idle_clocks(30);
    check("busy", 25'(busy), 25'h0000000);
    check("idle writes", 25'(n_wr - n0), 25'h0000000);
  endtask : t_ignore
  initial
  begin
    sys_rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_write_read(9'h1A5, 16'hA55A);
    t_write_read(9'h000, 16'h8001);
    t_write_read(9'h1FF, 16'hFFFE);
    t_abort(9'h1A5, 16'hA55A);
    t_ignore();
    summarize();
  end
  // Frames are 26 or 20 bits long, so this only trips on a hang
  initial
  begin
    #200000;
    failures++;
    summarize();
  end
endmodule : tb
